// ===== design/mipc_pkg.sv
/*
  Shared constants and types of the maskable interrupt priority controller:
  register indices, field positions, reset values, state codes and carriers.
  Assumes a 32-bit APB slave whose byte address is four times a register index.
*/
package mipc_pkg;

  localparam int NUM_SRC = 20;
  localparam int SRC_W   = 5;
  localparam int LVL_W   = 3;
  localparam int NUM_LVL = 8;
  localparam int ADDR_W  = 12;

  // Printed register offsets, kept as register indices
  localparam logic [31:0] CTRL_OFFSET [NUM_SRC] = '{
    32'hFFFFF110, 32'hFFFFF112, 32'hFFFFF114, 32'hFFFFF116, 32'hFFFFF118,
    32'hFFFFF11A, 32'hFFFFF11C, 32'hFFFFF11E, 32'hFFFFF120, 32'hFFFFF122,
    32'hFFFFF124, 32'hFFFFF126, 32'hFFFFF128, 32'hFFFFF12A, 32'hFFFFF12C,
    32'hFFFFF12E, 32'hFFFFF130, 32'hFFFFF132, 32'hFFFFF134, 32'hFFFFF136
  };

  // Index bits seen on paddr[ADDR_W-1:2]
  localparam logic [9:0] CTRL_IDX_FIRST = 10'h110;
  localparam logic [9:0] CTRL_IDX_LAST  = 10'h136;
  localparam logic [9:0] STATUS_IDX     = 10'h100;
  localparam logic [9:0] MASK_IDX       = 10'h101;
  localparam logic [9:0] INSERV_IDX     = 10'h102;

  // Fields of a source control register
  localparam int REQ_BIT   = 7;
  localparam int BLOCK_BIT = 6;
  localparam int LVL_MSB   = 2;

  localparam logic [7:0]         CTRL_RESET   = 8'h47;
  localparam logic [NUM_SRC-1:0] STATUS_RESET = 20'h00000;
  localparam logic [NUM_SRC-1:0] MASK_RESET   = 20'hFFFFF;
  localparam logic [NUM_LVL-1:0] INSERV_RESET = 8'h00;

  typedef enum logic [1:0] {
    MIPC_IDLE  = 2'b00,
    MIPC_OFFER = 2'b01,
    MIPC_ACKED = 2'b11
  } mipc_state_t;

  // Request presented to the CPU core
  typedef struct packed {
    logic             valid;
    logic [SRC_W-1:0] source;
    logic [LVL_W-1:0] level;
  } mipc_offer_t;

  // Result of decoding a control register address
  typedef struct packed {
    logic             hit;
    logic [SRC_W-1:0] src;
  } mipc_decode_t;

endpackage : mipc_pkg

// ===== design/mipc_ctrl.sv
/*
  Maskable interrupt priority controller: per-source control registers with
  request flag, mask flag and priority level, level-then-default-order
  arbitration, nested acknowledge tracking, and an APB register slave with a
  sticky event status, an event mask and one level interrupt output.
  Assumes the CPU core sends a one-cycle acknowledge while an offer is valid,
  a one-cycle return pulse at the end of each service routine, and presents
  its global block and non-maskable service flags as levels on pclk.
*/
// Implementation choice: register access over APB.
// Contract
// - Acknowledge may occur while other service runs; nesting follows priority levels.
// - Each source has a 3-bit level of eight; arbitration uses level first.
// - Equal-level simultaneous requests resolve by fixed per-source default order.
// - Acknowledging a maskable request sets the CPU global block flag to 1.
// - Every source has its own control register, byte or single-bit accessible.
// - Reset loads every control register with 47H.
// - Bit 7 is the request flag: 1 request issued, 0 none.
// - Bit 6 is the mask flag: 0 allows service, 1 holds request pending.
// - Bits 2..0 give level in binary, 0 highest, 7 lowest.
// - Control registers at consecutive even offsets from FFFFF110H; bits 5..3 zero.
// - Masked or blocked requests stay pending, then are served by priority.
`timescale 1ns/10ps
module mipc_ctrl #(
  parameter int NUM_SRC = mipc_pkg::NUM_SRC,
  parameter int ADDR_W  = mipc_pkg::ADDR_W
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [ADDR_W-1:0]    paddr,
  input  wire logic [31:0]          pwdata,
  input  wire logic [3:0]           pstrb,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic [NUM_SRC-1:0]   source_req,
  input  wire logic                 global_irq_block_flag,
  input  wire logic                 nonmaskable_service_flag,
  input  wire logic                 irq_ack,
  input  wire logic                 irq_return,
  output mipc_pkg::mipc_offer_t     offer,
  output logic                      set_global_block,
  output logic                      irq
);

  localparam int SRC_W   = mipc_pkg::SRC_W;
  localparam int LVL_W   = mipc_pkg::LVL_W;
  localparam int NUM_LVL = mipc_pkg::NUM_LVL;

  logic [NUM_SRC-1:0]            request_pending_flag;
  logic [NUM_SRC-1:0]            source_block_flag;
  logic [NUM_SRC-1:0][LVL_W-1:0] priority_level_field;
  logic [NUM_SRC-1:0]            status;
  logic [NUM_SRC-1:0]            mask;
  logic [NUM_LVL-1:0]            in_service;
  mipc_pkg::mipc_state_t         state;
  mipc_pkg::mipc_offer_t         best;
  mipc_pkg::mipc_decode_t        dec;
  logic                          best_ok;
  logic                          ack_take;
  logic                          wr_done;
  logic [7:0]                    wr_mask;
  logic [31:0]                   next_prdata;
  logic                          next_pslverr;
  logic [9:0]                    word_idx;

  // Map a word index to a source: consecutive even indices from the first
  function automatic mipc_pkg::mipc_decode_t decode_src(input logic [9:0] idx);
    logic [9:0] rel;
    decode_src = '0;
    rel        = idx - mipc_pkg::CTRL_IDX_FIRST;
    if (idx >= mipc_pkg::CTRL_IDX_FIRST && idx <= mipc_pkg::CTRL_IDX_LAST && !rel[0]) begin
      decode_src.hit = 1'b1;
      decode_src.src = rel[SRC_W:1];
    end
  endfunction : decode_src

  // Lowest level wins; at equal level the lower source number wins
  function automatic mipc_pkg::mipc_offer_t pick_best(
    input logic [NUM_SRC-1:0]            cand,
    input logic [NUM_SRC-1:0][LVL_W-1:0] lvl
  );
    pick_best = '0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (cand[i] && (!pick_best.valid || lvl[i] <= pick_best.level)) begin
        pick_best.valid  = 1'b1;
        pick_best.source = SRC_W'(i);
        pick_best.level  = lvl[i];
      end
    end
  endfunction : pick_best

  // True when the level outranks every level now in service
  function automatic logic outranks(
    input logic [LVL_W-1:0]   lvl,
    input logic [NUM_LVL-1:0] busy
  );
    outranks = 1'b1;
    for (int l = 0; l < NUM_LVL; l++) begin
      if (busy[l] && LVL_W'(l) <= lvl) begin
        outranks = 1'b0;
      end
    end
  endfunction : outranks

  assign word_idx = paddr[11:2];
  assign dec      = decode_src(word_idx);
  assign wr_done  = psel && penable && pready && pwrite && !pslverr;
  assign ack_take = (state == mipc_pkg::MIPC_OFFER) && irq_ack;

  // Full byte on lane 0; lane 1 alone selects single bits of lane 0
  always_comb begin
    wr_mask = 8'h00;
    if (pstrb[0]) begin
      wr_mask = 8'hFF;
    end else if (pstrb[1]) begin
      wr_mask = pwdata[15:8];
    end
  end

  // Pending sources that may be offered; others stay held
  assign best    = pick_best(request_pending_flag & ~source_block_flag, priority_level_field);
  assign best_ok = best.valid && !global_irq_block_flag && !nonmaskable_service_flag
                   && outranks(best.level, in_service);

  // Request flags: a new request wins over any clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      request_pending_flag <= '0;
    end else begin
      for (int i = 0; i < NUM_SRC; i++) begin
        if (source_req[i]) begin
          request_pending_flag[i] <= 1'b1;
        end else if (ack_take && offer.source == SRC_W'(i)) begin
          request_pending_flag[i] <= 1'b0;
        end else if (wr_done && dec.hit && dec.src == SRC_W'(i)
                     && wr_mask[mipc_pkg::REQ_BIT]) begin
          request_pending_flag[i] <= pwdata[mipc_pkg::REQ_BIT];
        end
      end
    end
  end

  // Mask flags and priority levels
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_SRC; i++) begin
        source_block_flag[i]    <= mipc_pkg::CTRL_RESET[mipc_pkg::BLOCK_BIT];
        priority_level_field[i] <= mipc_pkg::CTRL_RESET[mipc_pkg::LVL_MSB:0];
      end
    end else if (wr_done && dec.hit) begin
      if (wr_mask[mipc_pkg::BLOCK_BIT]) begin
        source_block_flag[dec.src] <= pwdata[mipc_pkg::BLOCK_BIT];
      end
      for (int b = 0; b <= mipc_pkg::LVL_MSB; b++) begin
        if (wr_mask[b]) begin
          priority_level_field[dec.src][b] <= pwdata[b];
        end
      end
    end
  end

  // Offer sequencing towards the CPU core
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state            <= mipc_pkg::MIPC_IDLE;
      offer            <= '0;
      set_global_block <= 1'b0;
    end else begin
      unique case (state)
        mipc_pkg::MIPC_IDLE: begin
          set_global_block <= 1'b0;
          if (best_ok) begin
            offer <= best;
            state <= mipc_pkg::MIPC_OFFER;
          end
        end
        mipc_pkg::MIPC_OFFER: begin
          if (irq_ack) begin
            offer            <= '0;
            set_global_block <= 1'b1;
            state            <= mipc_pkg::MIPC_ACKED;
          end else if (best_ok) begin
            offer <= best;
          end else begin
            offer <= '0;
            state <= mipc_pkg::MIPC_IDLE;
          end
        end
        mipc_pkg::MIPC_ACKED: begin
          set_global_block <= 1'b0;
          state            <= mipc_pkg::MIPC_IDLE;
        end
        default: begin
          offer            <= '0;
          set_global_block <= 1'b0;
          state            <= mipc_pkg::MIPC_IDLE;
        end
      endcase
    end
  end

  // Levels now in service; a return ends the highest-ranked one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_service <= mipc_pkg::INSERV_RESET;
    end else begin
      logic [NUM_LVL-1:0] busy;
      logic               done;
      busy = in_service;
      done = 1'b0;
      if (irq_return) begin
        for (int l = 0; l < NUM_LVL; l++) begin
          if (busy[l] && !done) begin
            busy[l] = 1'b0;
            done    = 1'b1;
          end
        end
      end
      if (ack_take) begin
        busy[offer.level] = 1'b1;
      end
      in_service <= busy;
    end
  end

  // Sticky event status, cleared by writing one; new events win
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= mipc_pkg::STATUS_RESET;
    end else if (wr_done && word_idx == mipc_pkg::STATUS_IDX) begin
      status <= (status & ~pwdata[NUM_SRC-1:0]) | source_req;
    end else begin
      status <= status | source_req;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask <= mipc_pkg::MASK_RESET;
    end else if (wr_done && word_idx == mipc_pkg::MASK_IDX) begin
      mask <= pwdata[NUM_SRC-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status & ~mask);
    end
  end

  // Read mux; unmapped words answer zero with an error
  always_comb begin
    next_prdata  = 32'h00000000;
    next_pslverr = 1'b0;
    if (dec.hit) begin
      next_prdata[mipc_pkg::REQ_BIT]       = request_pending_flag[dec.src];
      next_prdata[mipc_pkg::BLOCK_BIT]     = source_block_flag[dec.src];
      next_prdata[mipc_pkg::LVL_MSB:0]     = priority_level_field[dec.src];
    end else if (word_idx == mipc_pkg::STATUS_IDX) begin
      next_prdata[NUM_SRC-1:0] = status;
    end else if (word_idx == mipc_pkg::MASK_IDX) begin
      next_prdata[NUM_SRC-1:0] = mask;
    end else if (word_idx == mipc_pkg::INSERV_IDX) begin
      next_prdata[NUM_LVL-1:0] = in_service;
    end else begin
      next_pslverr = 1'b1;
    end
  end

  // One wait state: answer registered in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else if (psel && penable && !pready) begin
      pready  <= 1'b1;
      pslverr <= next_pslverr;
      prdata  <= pwrite ? 32'h00000000 : next_prdata;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

endmodule : mipc_ctrl

// ===== verif/mipc_ctrl_properties.sv
/*
  Concurrent checks on the ports of the interrupt priority controller.
  Assumes binding into mipc_ctrl, one clock pclk, async reset presetn.
*/
`timescale 1ns/10ps
module mipc_ctrl_properties #(
  parameter int NUM_SRC = mipc_pkg::NUM_SRC,
  parameter int ADDR_W  = mipc_pkg::ADDR_W
) (
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic [31:0]           prdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  input wire logic                  global_irq_block_flag,
  input wire logic                  irq_ack,
  input wire mipc_pkg::mipc_offer_t offer,
  input wire logic                  set_global_block
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ack_offer: assert property (
    irq_ack && offer.valid |=> set_global_block && !offer.valid ##1 !set_global_block)
    else $error("acknowledge not answered");
  a_block_cause: assert property (
    set_global_block |-> $past(irq_ack) && $past(offer.valid))
    else $error("block pulse without acknowledge");
  a_blocked_hold: assert property (
    $past(global_irq_block_flag) |-> !offer.valid)
    else $error("offer while blocked");
  a_ready_access: assert property (
    pready |-> psel && penable)
    else $error("ready outside access");
  a_ready_pulse: assert property (
    pready |=> !pready)
    else $error("ready longer than one cycle");
  a_access_wait: assert property (
    psel && !penable |=> !pready ##1 pready)
    else $error("ready latency wrong");
  a_err_zero: assert property (
    pslverr |-> pready && prdata == 32'h00000000)
    else $error("error response malformed");
  a_offer_src: assert property (
    offer.valid |-> offer.source < NUM_SRC)
    else $error("offer from unknown source");
endmodule : mipc_ctrl_properties

// ===== verif/mipc_cpu_model.sv
/*
  CPU core model: acknowledges each valid offer and keeps the global block flag.
  Assumes the controller's pclk; the bench clears the flag through clr_id.
*/
`timescale 1ns/10ps
module mipc_cpu_model (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire mipc_pkg::mipc_offer_t offer,
  input  wire logic                  set_global_block,
  input  wire logic                  clr_id,
  output logic                       irq_ack,
  output logic                       id_flag,
  output logic [4:0]                 acked_src,
  output int                         acked_n
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_ack   <= 1'b0;
      acked_src <= 5'h00;
      acked_n   <= 0;
    end else begin
      irq_ack <= offer.valid && !irq_ack;
      if (irq_ack && offer.valid) begin
        acked_src <= offer.source;
        acked_n   <= acked_n + 1;
      end
    end
  end
  // Starts blocked, as the status word does out of reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) id_flag <= 1'b1;
    else if (set_global_block) id_flag <= 1'b1;
    else if (clr_id) id_flag <= 1'b0;
  end
endmodule : mipc_cpu_model

// ===== verif/mipc_ctrl_test.sv
/*
  Self-checking bench: APB master, request sources and CPU model.
  Assumes nothing outside; the non-maskable service flag is held low.
*/
`timescale 1ns/10ps
module mipc_ctrl_test;
  logic                  pclk = 1'b0;
  logic                  presetn = 1'b0;
  logic                  psel = 1'b0;
  logic                  penable = 1'b0;
  logic                  pwrite = 1'b0;
  logic [11:0]           paddr = 12'h000;
  logic [31:0]           pwdata = 32'h00000000;
  logic [3:0]            pstrb = 4'h0;
  logic [19:0]           source_req = 20'h00000;
  logic                  irq_return = 1'b0;
  logic                  clr_id = 1'b0;
  logic [31:0]           prdata, rd;
  logic                  pready, pslverr, er, irq_ack, id_flag, set_global_block, irq;
  mipc_pkg::mipc_offer_t offer;
  logic [4:0]            acked_src;
  int                    acked_n, errors = 0, total_checks = 0, cyc = 0;
  always #2.5 pclk = ~pclk;
  mipc_ctrl uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .source_req(source_req),
    .global_irq_block_flag(id_flag), .nonmaskable_service_flag(1'b0), .irq_ack(irq_ack),
    .irq_return(irq_return), .offer(offer), .set_global_block(set_global_block), .irq(irq));
  mipc_cpu_model cpu (.pclk(pclk), .presetn(presetn), .offer(offer),
    .set_global_block(set_global_block), .clr_id(clr_id), .irq_ack(irq_ack),
    .id_flag(id_flag), .acked_src(acked_src), .acked_n(acked_n));
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : report_and_stop
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      report_and_stop;
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  function automatic logic [11:0] ca(input int i);
    return 12'(12'h440 + 8 * i);
  endfunction : ca
  task automatic rdc(input int i, input logic [7:0] e);
    apb(1'b0, ca(i), 32'h00000000, 4'h0);
    chk("ctrl", rd, {24'h000000, e});
  endtask : rdc
  task automatic pulse(input logic [19:0] m);
    @(posedge pclk) source_req <= m;
    @(posedge pclk) source_req <= 20'h00000;
  endtask : pulse
  // Clears the block flag, optionally ending the innermost service routine
  task automatic rel(input logic r);
    @(posedge pclk);
    clr_id <= 1'b1;
    irq_return <= r;
    @(posedge pclk);
    clr_id <= 1'b0;
    irq_return <= 1'b0;
  endtask : rel
  task automatic wacks(input int n);
    for (int k = 0; k < 40 && acked_n < n; k++) @(posedge pclk);
    chk("acks", acked_n, n);
  endtask : wacks
  task automatic t_reset;
    for (int i = 0; i < 20; i++) rdc(i, 8'h47);
    apb(1'b0, 12'h400, 32'h00000000, 4'h0);
    chk("status", rd, 32'h00000000);
    apb(1'b0, 12'h404, 32'h00000000, 4'h0);
    chk("mask", rd, 32'h000FFFFF);
    apb(1'b0, 12'h0FC, 32'h00000000, 4'h0);
    chk("unmapped", {rd[30:0], er}, 32'h00000001);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_fields;
    apb(1'b1, ca(0), 32'h0000003D, 4'h1);
    rdc(0, 8'h05);
    apb(1'b1, ca(0), 32'h00004040, 4'h2);
    rdc(0, 8'h45);
    $display("t_fields done");
  endtask : t_fields
  task automatic t_prio;
    apb(1'b1, ca(2), 32'h00000003, 4'h1);
    apb(1'b1, ca(5), 32'h00000001, 4'h1);
    apb(1'b1, ca(7), 32'h00000001, 4'h1);
    pulse(20'h000A4);
    rdc(5, 8'h81);
    rel(1'b0);
    wacks(1);
    chk("first", acked_src, 32'h00000005);
    rdc(5, 8'h01);
    rel(1'b0);
    repeat (8) @(posedge pclk);
    chk("same level", acked_n, 32'h00000001);
    rel(1'b1);
    wacks(2);
    chk("second", acked_src, 32'h00000007);
    rel(1'b1);
    wacks(3);
    chk("third", acked_src, 32'h00000002);
    $display("t_prio done");
  endtask : t_prio
  task automatic t_nest;
    rel(1'b0);
    pulse(20'h00020);
    wacks(4);
    chk("nested", acked_src, 32'h00000005);
    apb(1'b0, 12'h408, 32'h00000000, 4'h0);
    chk("in service", rd, 32'h0000000A);
    rel(1'b1);
    rel(1'b1);
    apb(1'b0, 12'h408, 32'h00000000, 4'h0);
    chk("in service", rd, 32'h00000000);
    $display("t_nest done");
  endtask : t_nest
  task automatic t_mask;
    apb(1'b1, 12'h400, 32'h000FFFFF, 4'hF);
    pulse(20'h00200);
    repeat (4) @(posedge pclk);
    chk("irq masked", irq, 32'h00000000);
    rdc(9, 8'hC7);
    apb(1'b1, 12'h404, 32'h000FFDFF, 4'hF);
    repeat (2) @(posedge pclk);
    chk("irq", irq, 32'h00000001);
    apb(1'b1, 12'h400, 32'h00000200, 4'hF);
    repeat (2) @(posedge pclk);
    chk("irq cleared", irq, 32'h00000000);
    chk("held", acked_n, 32'h00000004);
    // Single-bit write of the mask flag only, so the pending flag survives
    apb(1'b1, ca(9), 32'h00004000, 4'h2);
    wacks(5);
    chk("released", acked_src, 32'h00000009);
    $display("t_mask done");
  endtask : t_mask
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_fields;
    t_prio;
    t_nest;
    t_mask;
    report_and_stop;
  end
endmodule : mipc_ctrl_test
bind mipc_ctrl mipc_ctrl_properties #(.NUM_SRC(NUM_SRC), .ADDR_W(ADDR_W)) u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .global_irq_block_flag(global_irq_block_flag),
  .irq_ack(irq_ack), .offer(offer), .set_global_block(set_global_block));
